// ### nvm_access_control.sv
// nonvolatile memory access controller with apb register slave
// How it works
// - byte data register plus separate address register
// - eeprom byte write erases then programs, self-timed
// - bit 7 picks flash or eeprom
// - bit 6 picks configuration space
// - bit 5 always reads zero
// - row erase bit held, self clears when a flash write completes
// - error flag on aborted or improper write
// - select bits kept on error
// - write enable gates writes, cleared at power-up
// - write start bit set only, hardware clears
// - completion sets irq flag, software clears
// - read start one cycle, refused for flash
// - unlock address holds nothing, reads zero
// - flash writes need the unlock sequence too
// - table pointer 21 bits, upper byte five bits
// - 55h then aah then write start
// - start needs prior enable; control, eeprom address and eeprom data registers locked while busy
// - writes blocked during power-up timer
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module nvm_access_control #(
  parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES,
  parameter int PWRT_CYCLES  = nvm_pkg::PWRT_CYCLES,
  parameter int CNT_W        = 16
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        WARM_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  output var  logic        BUSY,
  output var  logic        WRITE_DONE_FLAG
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]                      tptr_low_ff;
  logic [7:0]                      tptr_high_ff;
  logic [nvm_pkg::TPTR_UPPER_W-1:0] tptr_upper_ff;
  logic [7:0]                      tlatch_ff;
  logic [7:0]                      ee_data_ff;
  logic [nvm_pkg::EE_ADDR_W-1:0]   ee_addr_ff;
  logic [7:0]                      pflags2_ff;
  logic [7:0]                      penables2_ff;
  logic [7:0]                      pprio2_ff;
  logic [7:0]                      int_ctrl_ff;
  logic                            mem_select_ff;
  logic                            config_select_ff;
  logic                            row_erase_ff;
  logic                            write_error_ff;
  logic                            write_enable_ff;
  logic                            write_start_ff;
  logic                            read_start_ff;
  nvm_pkg::target_t                target_ff;
  nvm_pkg::unlock_state_t          lock_ff;
  nvm_pkg::unlock_state_t          nxt_lock;
  logic [CNT_W-1:0]                op_cnt_ff;
  logic [CNT_W-1:0]                pwrt_cnt_ff;
  logic                            pwrt_done_ff;
  logic [31:0]                     prdata_ff;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       wr_acc;
  logic       rd_setup;
  logic       hit;
  logic [7:0] wbyte;
  logic       ctrl_wr;
  logic       unlock_wr;
  logic       start_req;
  logic       start_ok;
  logic       op_done;
  logic       abort;
  logic [7:0] rd_byte;

  assign wr_acc    = CE & PSEL & PENABLE & PWRITE;
  assign rd_setup  = CE & PSEL & ~PENABLE & ~PWRITE;
  assign wbyte     = PWDATA[7:0];
  assign ctrl_wr   = wr_acc & (PADDR == nvm_pkg::OFS_MEM_CTRL);
  assign unlock_wr = wr_acc & (PADDR == nvm_pkg::OFS_MEM_UNLOCK);

  always_comb begin
    case (PADDR)
      nvm_pkg::OFS_TPTR_LOW, nvm_pkg::OFS_TPTR_HIGH, nvm_pkg::OFS_TPTR_UPPER,
      nvm_pkg::OFS_TLATCH, nvm_pkg::OFS_MEM_CTRL, nvm_pkg::OFS_MEM_UNLOCK,
      nvm_pkg::OFS_EE_DATA, nvm_pkg::OFS_EE_ADDR, nvm_pkg::OFS_PFLAGS2,
      nvm_pkg::OFS_PENABLES2, nvm_pkg::OFS_PPRIO2, nvm_pkg::OFS_INT_CTRL: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  assign PREADY  = CE;
  assign PSLVERR = PSEL & PENABLE & ~hit;
  assign PRDATA  = prdata_ff;
  assign BUSY    = write_start_ff;
  assign WRITE_DONE_FLAG = pflags2_ff[nvm_pkg::BIT_WR_IRQ];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (PADDR)
      nvm_pkg::OFS_TPTR_LOW:   rd_byte = tptr_low_ff;
      nvm_pkg::OFS_TPTR_HIGH:  rd_byte = tptr_high_ff;
      nvm_pkg::OFS_TPTR_UPPER: rd_byte = {3'h0, tptr_upper_ff};
      nvm_pkg::OFS_TLATCH:     rd_byte = tlatch_ff;
      nvm_pkg::OFS_MEM_CTRL:   rd_byte = {mem_select_ff, config_select_ff, 1'b0,
                                          row_erase_ff, write_error_ff, write_enable_ff,
                                          write_start_ff, read_start_ff};
      nvm_pkg::OFS_MEM_UNLOCK: rd_byte = 8'h00;
      nvm_pkg::OFS_EE_DATA:    rd_byte = ee_data_ff;
      nvm_pkg::OFS_EE_ADDR:    rd_byte = ee_addr_ff;
      nvm_pkg::OFS_PFLAGS2:    rd_byte = pflags2_ff;
      nvm_pkg::OFS_PENABLES2:  rd_byte = penables2_ff;
      nvm_pkg::OFS_PPRIO2:     rd_byte = pprio2_ff;
      nvm_pkg::OFS_INT_CTRL:   rd_byte = int_ctrl_ff;
      default:                 rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // power-up timer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pwrt_cnt_ff  <= '0;
      pwrt_done_ff <= 1'b0;
    end else if (CE && !pwrt_done_ff) begin
      pwrt_cnt_ff <= pwrt_cnt_ff + 1'b1;
      if (pwrt_cnt_ff == CNT_W'(PWRT_CYCLES - 1)) begin
        pwrt_done_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------
  always_comb begin
    nxt_lock = lock_ff;
    if (wr_acc) begin
      if (unlock_wr && wbyte == nvm_pkg::UNLOCK_FIRST) begin
        nxt_lock = nvm_pkg::LOCK_FIRST;
      end else if (unlock_wr && wbyte == nvm_pkg::UNLOCK_SECOND &&
                   lock_ff == nvm_pkg::LOCK_FIRST) begin
        nxt_lock = nvm_pkg::LOCK_ARMED;
      end else begin
        nxt_lock = nvm_pkg::LOCK_IDLE;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lock_ff <= nvm_pkg::LOCK_IDLE;
    end else if (CE) begin
      if (WARM_RST) begin
        lock_ff <= nvm_pkg::LOCK_IDLE;
      end else begin
        lock_ff <= nxt_lock;
      end
    end
  end

  // ----------------------------------------------------------------
  // write start qualification
  // ----------------------------------------------------------------
  assign start_req = ctrl_wr & wbyte[nvm_pkg::BIT_WR_START] & ~write_start_ff & ~WARM_RST;
  // enable must already be set; same write cannot supply it
  assign start_ok  = start_req & (lock_ff == nvm_pkg::LOCK_ARMED) &
                     write_enable_ff & pwrt_done_ff;
  assign op_done   = write_start_ff & (op_cnt_ff == '0) & ~WARM_RST;
  assign abort     = write_start_ff & WARM_RST;

  // ----------------------------------------------------------------
  // self-timed operation counter and target
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      op_cnt_ff <= '0;
      target_ff <= nvm_pkg::TGT_EEPROM;
    end else if (CE) begin
      if (start_ok) begin
        op_cnt_ff <= CNT_W'(WRITE_CYCLES - 1);
        if (config_select_ff) begin
          target_ff <= nvm_pkg::TGT_CONFIG;
        end else if (mem_select_ff) begin
          target_ff <= nvm_pkg::TGT_FLASH;
        end else begin
          target_ff <= nvm_pkg::TGT_EEPROM;
        end
      end else if (write_start_ff && op_cnt_ff != '0) begin
        op_cnt_ff <= op_cnt_ff - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // memory_control bits
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mem_select_ff    <= 1'b0;
      config_select_ff <= 1'b0;
      write_enable_ff  <= 1'b0;
      read_start_ff    <= 1'b0;
    end else if (CE) begin
      read_start_ff <= 1'b0;
      if (WARM_RST) begin
        write_enable_ff <= 1'b0;
      end else if (ctrl_wr && !write_start_ff) begin
        mem_select_ff    <= wbyte[nvm_pkg::BIT_MEM_SEL];
        config_select_ff <= wbyte[nvm_pkg::BIT_CFG_SEL];
        write_enable_ff  <= wbyte[nvm_pkg::BIT_WR_EN];
        read_start_ff    <= wbyte[nvm_pkg::BIT_RD_START] & ~read_start_ff &
                            ~wbyte[nvm_pkg::BIT_MEM_SEL] & ~wbyte[nvm_pkg::BIT_CFG_SEL];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      row_erase_ff <= 1'b0;
    end else if (CE) begin
      if (WARM_RST) begin
        row_erase_ff <= 1'b0;
      end else if (op_done && target_ff == nvm_pkg::TGT_FLASH) begin
        row_erase_ff <= 1'b0;
      end else if (ctrl_wr && !write_start_ff) begin
        row_erase_ff <= wbyte[nvm_pkg::BIT_ROW_ERASE];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      write_start_ff <= 1'b0;
    end else if (CE) begin
      if (abort || op_done) begin
        write_start_ff <= 1'b0;
      end else if (start_ok) begin
        write_start_ff <= 1'b1;
      end
    end
  end

  // error flag: set wins over software write and completion
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      write_error_ff <= 1'b0;
    end else if (CE) begin
      if (abort || (start_req && !start_ok)) begin
        write_error_ff <= 1'b1;
      end else if (op_done) begin
        write_error_ff <= 1'b0;
      end else if (ctrl_wr && !write_start_ff) begin
        write_error_ff <= wbyte[nvm_pkg::BIT_WR_ERR];
      end
    end
  end

  // ----------------------------------------------------------------
  // eeprom address and data
  // ----------------------------------------------------------------
  nvm_mem_if #(.AW(nvm_pkg::EE_ADDR_W)) ee_bus ();

  assign ee_bus.ce       = CE;
  assign ee_bus.addr     = ee_addr_ff;
  assign ee_bus.wdata    = ee_data_ff;
  assign ee_bus.erase_en = write_start_ff & ~WARM_RST & (target_ff == nvm_pkg::TGT_EEPROM) &
                           (op_cnt_ff == CNT_W'(WRITE_CYCLES - 1));
  assign ee_bus.prog_en  = op_done & (target_ff == nvm_pkg::TGT_EEPROM);

  nvm_eeprom_array #(.AW(nvm_pkg::EE_ADDR_W)) u_array (
    .CLK (CLK),
    .mem (ee_bus)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ee_addr_ff <= '0;
    end else if (CE && wr_acc && PADDR == nvm_pkg::OFS_EE_ADDR && !write_start_ff) begin
      ee_addr_ff <= wbyte[nvm_pkg::EE_ADDR_W-1:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ee_data_ff <= nvm_pkg::BYTE_RST;
    end else if (CE) begin
      if (read_start_ff) begin
        ee_data_ff <= ee_bus.rdata;
      end else if (wr_acc && PADDR == nvm_pkg::OFS_EE_DATA && !write_start_ff) begin
        ee_data_ff <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // table pointer and latch
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tptr_low_ff   <= nvm_pkg::BYTE_RST;
      tptr_high_ff  <= nvm_pkg::BYTE_RST;
      tptr_upper_ff <= '0;
      tlatch_ff     <= nvm_pkg::BYTE_RST;
    end else if (CE && wr_acc) begin
      case (PADDR)
        nvm_pkg::OFS_TPTR_LOW:   tptr_low_ff   <= wbyte;
        nvm_pkg::OFS_TPTR_HIGH:  tptr_high_ff  <= wbyte;
        nvm_pkg::OFS_TPTR_UPPER: tptr_upper_ff <= wbyte[nvm_pkg::TPTR_UPPER_W-1:0];
        nvm_pkg::OFS_TLATCH:     tlatch_ff     <= wbyte;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt related registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      penables2_ff <= nvm_pkg::BYTE_RST;
      pprio2_ff    <= nvm_pkg::BYTE_RST;
      int_ctrl_ff  <= nvm_pkg::BYTE_RST;
    end else if (CE && wr_acc) begin
      case (PADDR)
        nvm_pkg::OFS_PENABLES2: penables2_ff <= wbyte;
        nvm_pkg::OFS_PPRIO2:    pprio2_ff    <= wbyte;
        nvm_pkg::OFS_INT_CTRL:  int_ctrl_ff  <= wbyte;
        default: begin
        end
      endcase
    end
  end

  // completion flag: hardware set wins over software write
  generate
    for (genvar b = 0; b < 8; b++) begin : g_pflag
      if (b == nvm_pkg::BIT_WR_IRQ) begin : g_irq
        always_ff @(posedge CLK or posedge RST) begin
          if (RST) begin
            pflags2_ff[b] <= 1'b0;
          end else if (CE) begin
            if (op_done) begin
              pflags2_ff[b] <= 1'b1;
            end else if (wr_acc && PADDR == nvm_pkg::OFS_PFLAGS2) begin
              pflags2_ff[b] <= wbyte[b];
            end
          end
        end
      end else begin : g_plain
        always_ff @(posedge CLK or posedge RST) begin
          if (RST) begin
            pflags2_ff[b] <= 1'b0;
          end else if (CE && wr_acc && PADDR == nvm_pkg::OFS_PFLAGS2) begin
            pflags2_ff[b] <= wbyte[b];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### nvm_pkg.sv
// constants, offsets and types shared by the nonvolatile access controller
package nvm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_NS = 50000;
  localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRT_TIME_NS  = 100000;
  localparam int PWRT_CYCLES   = (PWRT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TPTR_LOW   = 8'h00;
  localparam logic [7:0] OFS_TPTR_HIGH  = 8'h04;
  localparam logic [7:0] OFS_TPTR_UPPER = 8'h08;
  localparam logic [7:0] OFS_TLATCH     = 8'h0c;
  localparam logic [7:0] OFS_MEM_CTRL   = 8'h10;
  localparam logic [7:0] OFS_MEM_UNLOCK = 8'h14;
  localparam logic [7:0] OFS_EE_DATA    = 8'h18;
  localparam logic [7:0] OFS_EE_ADDR    = 8'h1c;
  localparam logic [7:0] OFS_PFLAGS2    = 8'h20;
  localparam logic [7:0] OFS_PENABLES2  = 8'h24;
  localparam logic [7:0] OFS_PPRIO2     = 8'h28;
  localparam logic [7:0] OFS_INT_CTRL   = 8'h2c;

  // ----------------------------------------------------------------
  // memory_control field positions, completion flag bit and table pointer upper width
  // ----------------------------------------------------------------
  localparam int BIT_MEM_SEL   = 7;
  localparam int BIT_CFG_SEL   = 6;
  localparam int BIT_UNUSED    = 5;
  localparam int BIT_ROW_ERASE = 4;
  localparam int BIT_WR_ERR    = 3;
  localparam int BIT_WR_EN     = 2;
  localparam int BIT_WR_START  = 1;
  localparam int BIT_RD_START  = 0;
  localparam int BIT_WR_IRQ    = 4;
  localparam int TPTR_UPPER_W  = 5;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  localparam int         EE_ADDR_W     = 8;

  typedef enum logic [1:0] {LOCK_IDLE, LOCK_FIRST, LOCK_ARMED} unlock_state_t;
  typedef enum logic [1:0] {TGT_EEPROM, TGT_FLASH, TGT_CONFIG} target_t;

endpackage

// ### nvm_mem_if.sv
// link between the controller and the data eeprom array
`timescale 1ns/10ps
`default_nettype none
interface nvm_mem_if #(parameter int AW = 8);
  logic          ce;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic          erase_en;
  logic          prog_en;

  modport ctrl (output ce, output addr, output wdata, output erase_en, output prog_en,
                input rdata);
  modport mem  (input ce, input addr, input wdata, input erase_en, input prog_en,
                output rdata);
endinterface
`default_nettype wire

// ### nvm_eeprom_array.sv
// byte wide data eeprom storage with erase and program strobes
`timescale 1ns/10ps
`default_nettype none
module nvm_eeprom_array #(
  parameter int AW = 8
) (
  input wire logic CLK,
  nvm_mem_if.mem   mem
);
  logic [7:0] cells [2**AW];

  assign mem.rdata = cells[mem.addr];

  // ----------------------------------------------------------------
  // erase first, program later
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (mem.ce) begin
      if (mem.erase_en) begin
        cells[mem.addr] <= nvm_pkg::ERASED_BYTE;
      end else if (mem.prog_en) begin
        cells[mem.addr] <= mem.wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### nvm_access_control_assertions.sv
// concurrent checks on the ports of the access controller
`timescale 1ns/10ps
`default_nettype none
module nvm_access_control_assertions #(
  parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        WARM_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        BUSY,
  input wire logic        WRITE_DONE_FLAG
);
  // ----------------------------------------------------------------
  // helpers and properties
  // ----------------------------------------------------------------
  int   busy_cnt;
  logic ctrl_wr;
  logic flag_wr;
  logic rd_acc;
  assign ctrl_wr = PSEL && PENABLE && PWRITE && CE && (PADDR == nvm_pkg::OFS_MEM_CTRL);
  assign flag_wr = PSEL && PENABLE && PWRITE && CE && (PADDR == nvm_pkg::OFS_PFLAGS2);
  assign rd_acc  = PSEL && PENABLE && !PWRITE;

  // counts enabled cycles of one busy stretch
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      busy_cnt <= 0;
    end else if (CE) begin
      busy_cnt <= BUSY ? busy_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_start_cause: assert property ($rose(BUSY) |-> $past(ctrl_wr && PWDATA[1]))
    else $error("busy rose without a start write");
  a_busy_bounded: assert property (busy_cnt <= WRITE_CYCLES)
    else $error("busy lasted too long");
  a_done_sets_flag: assert property ($fell(BUSY) && !$past(WARM_RST) |-> WRITE_DONE_FLAG)
    else $error("completion did not set flag");
  a_flag_cause: assert property ($rose(WRITE_DONE_FLAG) |-> $fell(BUSY) || $past(flag_wr))
    else $error("flag rose without completion");
  a_flag_sticky: assert property (WRITE_DONE_FLAG && !flag_wr && !WARM_RST |=> WRITE_DONE_FLAG)
    else $error("flag cleared by hardware");
  a_warm_abort: assert property (BUSY && WARM_RST && CE |=> !BUSY)
    else $error("warm reset did not abort");
  a_unlock_zero: assert property (rd_acc && PADDR == nvm_pkg::OFS_MEM_UNLOCK |-> PRDATA == 32'h0)
    else $error("unlock address read nonzero");
  a_ctrl_clean: assert property (rd_acc && PADDR == nvm_pkg::OFS_MEM_CTRL
                                 |-> PRDATA[5] == 1'b0 && PRDATA[31:8] == 24'h0)
    else $error("control unused bits nonzero");

  cover property ($fell(BUSY) && WRITE_DONE_FLAG);
  cover property (BUSY && WARM_RST);
  cover property (rd_acc && PADDR == nvm_pkg::OFS_MEM_UNLOCK);
  cover property (BUSY && !CE);
endmodule
bind nvm_access_control nvm_access_control_assertions #(.WRITE_CYCLES(WRITE_CYCLES))
  nvm_access_control_assertions_inst (
  .CLK(CLK), .RST(RST), .CE(CE), .WARM_RST(WARM_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .BUSY(BUSY), .WRITE_DONE_FLAG(WRITE_DONE_FLAG));
`default_nettype wire

// ### nvm_access_control_tb.sv
// self-checking bench for the access controller
`timescale 1ns/10ps
`default_nettype none
module nvm_access_control_tb;
  // ----------------------------------------------------------------
  // signals and tasks
  // ----------------------------------------------------------------
  localparam int         WCYC = 8;
  localparam logic [7:0] CTRL = nvm_pkg::OFS_MEM_CTRL;
  localparam logic [7:0] UNL  = nvm_pkg::OFS_MEM_UNLOCK;
  logic        clk, rst, ce, warm_rst, psel, penable, pwrite, pready, pslverr, busy, flag, serr;
  logic [7:0]  paddr, q;
  logic [31:0] pwdata, prdata;
  int          error_cnt, samples_checked, n;

  nvm_access_control #(.WRITE_CYCLES(WCYC), .PWRT_CYCLES(40)) nvm_access_control_inst (
    .CLK(clk), .RST(rst), .CE(ce), .WARM_RST(warm_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BUSY(busy), .WRITE_DONE_FLAG(flag));

  always #12.5 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata[7:0];
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    xfer(1'b0, a, 8'h00);
    chk(nm, q, exp);
  endtask
  task automatic launch(input logic [7:0] c);
    xfer(1'b1, UNL, nvm_pkg::UNLOCK_FIRST);
    xfer(1'b1, UNL, nvm_pkg::UNLOCK_SECOND);
    xfer(1'b1, CTRL, c);
  endtask
  task automatic wait_idle;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {warm_rst, psel, penable, pwrite} = 4'h0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(CTRL, 8'h00, "ctrl_reset");
    rd(UNL, 8'h00, "unlock_read");
    xfer(1'b0, 8'h30, 8'h00);
    chk("slverr", {7'h00, serr}, 8'h01);
    xfer(1'b1, CTRL, 8'h04);
    launch(8'h06);
    #1;
    chk("busy_pwrt", {7'h00, busy}, 8'h00);
    rd(CTRL, 8'h0c, "ctrl_pwrt");
    $display("test power_up done");
    repeat (40) @(posedge clk);
    xfer(1'b1, nvm_pkg::OFS_EE_ADDR, 8'h05);
    xfer(1'b1, nvm_pkg::OFS_EE_DATA, 8'h3c);
    launch(8'h06);
    wait_idle;
    chk("busy_len", n[7:0], WCYC[7:0]);
    chk("done_flag", {7'h00, flag}, 8'h01);
    rd(CTRL, 8'h04, "ctrl_done");
    rd(nvm_pkg::OFS_PFLAGS2, 8'h10, "pflags");
    xfer(1'b1, nvm_pkg::OFS_EE_DATA, 8'h00);
    xfer(1'b1, CTRL, 8'h05);
    repeat (2) @(posedge clk);
    rd(CTRL, 8'h04, "rd_clear");
    rd(nvm_pkg::OFS_EE_DATA, 8'h3c, "ee_data");
    xfer(1'b1, nvm_pkg::OFS_PFLAGS2, 8'h00);
    #1;
    chk("flag_clr", {7'h00, flag}, 8'h00);
    $display("test eeprom done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, CTRL, (i == 3) ? 8'h00 : 8'h04);
      if (i == 1) begin
        xfer(1'b1, UNL, nvm_pkg::UNLOCK_SECOND);
        xfer(1'b1, UNL, nvm_pkg::UNLOCK_FIRST);
      end
      if (i == 2) begin
        xfer(1'b1, UNL, nvm_pkg::UNLOCK_FIRST);
        xfer(1'b1, nvm_pkg::OFS_EE_DATA, 8'h5a);
        xfer(1'b1, UNL, nvm_pkg::UNLOCK_SECOND);
      end
      if (i == 3)
        launch(8'h06);
      else
        xfer(1'b1, CTRL, 8'h06);
      #1;
      chk("busy_refused", {7'h00, busy}, 8'h00);
      rd(CTRL, 8'h0c, "ctrl_refused");
    end
    $display("test refused done");
    xfer(1'b1, CTRL, 8'h94);
    launch(8'h96);
    xfer(1'b1, nvm_pkg::OFS_EE_ADDR, 8'h77);
    wait_idle;
    rd(CTRL, 8'h84, "ctrl_flash");
    rd(nvm_pkg::OFS_EE_ADDR, 8'h05, "addr_locked");
    xfer(1'b1, CTRL, 8'h85);
    rd(CTRL, 8'h84, "rd_flash");
    xfer(1'b1, CTRL, 8'h45);
    rd(CTRL, 8'h44, "rd_config");
    rd(nvm_pkg::OFS_EE_DATA, 8'h5a, "rd_refused");
    launch(8'h46);
    #1;
    chk("busy_config", {7'h00, busy}, 8'h01);
    @(posedge clk);
    ce <= 1'b0;
    repeat (19) @(posedge clk);
    #1;
    chk("ready_frozen", {7'h00, pready}, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    #1;
    chk("ce_freeze", {7'h00, busy}, 8'h01);
    wait_idle;
    $display("test flash done");
    xfer(1'b1, nvm_pkg::OFS_PFLAGS2, 8'h00);
    xfer(1'b1, CTRL, 8'h84);
    launch(8'h86);
    @(posedge clk);
    warm_rst <= 1'b1;
    @(posedge clk);
    warm_rst <= 1'b0;
    wait_idle;
    chk("flag_abort", {7'h00, flag}, 8'h00);
    rd(CTRL, 8'h88, "ctrl_abort");
    xfer(1'b1, nvm_pkg::OFS_TPTR_UPPER, 8'hff);
    rd(nvm_pkg::OFS_TPTR_UPPER, 8'h1f, "tptr_upper");
    xfer(1'b1, nvm_pkg::OFS_TPTR_HIGH, 8'ha5);
    rd(nvm_pkg::OFS_TPTR_HIGH, 8'ha5, "tptr_high");
    $display("test abort done");
    end_sim;
  end

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
